// [acr_adapter_reset_control.sv]
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module acr_adapter_reset_control #(
  parameter int unsigned CONV_CYC = acr_pkg::CONV_WINDOW_CYC
) (
  input  wire logic                       mclk,         // 50 MHz clock
  input  wire logic                       sys_rst,      // Sync reset, high
  input  wire logic                       hostBusReset, // Host bus reset line, high
  input  wire logic                       phaseError,   // Invalid phase seen by monitor
  input  wire logic                       scsiRstInN,   // Sensed SCSI reset, low active
  output logic                            scsiRstOutN,  // SCSI reset drive level
  output logic                            scsiRstOe,    // SCSI reset drive enable
  output logic                            hostIrq,      // Host interrupt request
  output acr_pkg::acr_evt_s               evtOut,       // Events to internal logic
  input  wire logic [acr_pkg::ADDR_W-1:0] awaddr,       // AXI write address
  input  wire logic                       awvalid,      // AXI
  output logic                            awready,      // AXI
  input  wire logic [acr_pkg::DATA_W-1:0] wdata,        // AXI write data
  input  wire logic [3:0]                 wstrb,        // AXI byte strobes
  input  wire logic                       wvalid,       // AXI
  output logic                            wready,       // AXI
  output logic                            bvalid,       // AXI
  output logic [1:0]                      bresp,        // AXI
  input  wire logic                       bready,       // AXI
  input  wire logic [acr_pkg::ADDR_W-1:0] araddr,       // AXI read address
  input  wire logic                       arvalid,      // AXI
  output logic                            arready,      // AXI
  output logic                            rvalid,       // AXI
  output logic [acr_pkg::DATA_W-1:0]      rdata,        // AXI read data
  output logic [1:0]                      rresp,        // AXI
  input  wire logic                       rready        // AXI
);

  // ==========================================================================
  // Helpers
  function automatic logic isReg(input logic [acr_pkg::ADDR_W-1:0] a, input logic [acr_pkg::ADDR_W-1:0] ofs);
    return a[acr_pkg::ADDR_W-1:2] == ofs[acr_pkg::ADDR_W-1:2];
  endfunction : isReg

  localparam logic [acr_pkg::TMR_W-1:0] HOLD_LOAD = acr_pkg::TMR_W'(acr_pkg::SCSI_RST_HOLD_CYC - 1);
  localparam logic [acr_pkg::TMR_W-1:0] DIAG_LOAD = acr_pkg::TMR_W'(acr_pkg::DIAG_CYC - 1);
  localparam logic [acr_pkg::TMR_W-1:0] WIN_LOAD  = acr_pkg::TMR_W'(CONV_CYC);

  // ==========================================================================
  // Bus slave state
  logic                       awHave_reg, awHave_next;
  logic                       wHave_reg, wHave_next;
  logic [acr_pkg::ADDR_W-1:0] awAddr_reg, awAddr_next;
  logic [acr_pkg::DATA_W-1:0] wData_reg, wData_next;
  logic                       wLane0_reg, wLane0_next;
  logic                       awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0]                 bresp_next, rresp_next;
  logic [acr_pkg::DATA_W-1:0] rdata_next;
  logic                       doWrite, ctrlHit;
  logic                       hardReqHit, busReqHit, intClrHit, initDoneHit;

  // ==========================================================================
  // Reset sequencer state
  acr_pkg::acr_state_e        stateReg, state_next;
  acr_pkg::acr_cause_e        causeReg, cause_next;
  logic [acr_pkg::TMR_W-1:0]  timerReg, timer_next;
  logic [acr_pkg::TMR_W-1:0]  winReg, win_next;
  logic                       seenReg, seen_next;
  logic                       intvReg, interrupt_valid_flag_next;
  logic                       initReqReg, initReq_next;
  logic                       diagActiveReg, diagActive_next;
  logic                       scsiRstOe_next, hostIrq_next;
  acr_pkg::acr_evt_s          evt_next;
  logic                       hostRst, winActive, convHit, sensedHit;

  // Register write decode; only the low byte carries control bits
  assign doWrite     = awHave_reg && wHave_reg && !bvalid;
  assign ctrlHit     = doWrite && isReg(awAddr_reg, acr_pkg::CTRL_OFS) && wLane0_reg;
  assign hardReqHit  = ctrlHit && wData_reg[acr_pkg::CTRL_HARD_BIT];
  assign busReqHit   = ctrlHit && wData_reg[acr_pkg::CTRL_BUSRST_BIT];
  assign intClrHit   = ctrlHit && wData_reg[acr_pkg::CTRL_INTCLR_BIT];
  assign initDoneHit = ctrlHit && wData_reg[acr_pkg::CTRL_INITDONE_BIT];
  assign hostRst     = hostBusReset || hardReqHit;
  assign winActive   = winReg != '0;
  // Conversion only inside the window after a detected or phase-error reset
  assign convHit     = busReqHit && winActive && (stateReg == acr_pkg::ST_IDLE || stateReg == acr_pkg::ST_BUSFREE);
  assign sensedHit   = stateReg == acr_pkg::ST_IDLE && !scsiRstInN && !busReqHit;

  // ==========================================================================
  // AXI4-Lite next state: address and data taken in either order
  always_comb
  begin
    awHave_next = awHave_reg;
    wHave_next  = wHave_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wLane0_next = wLane0_reg;
    bvalid_next = bvalid;
    bresp_next  = bresp;
    rvalid_next = rvalid;
    rdata_next  = rdata;
    rresp_next  = rresp;
    if (awvalid && awready)
    begin
      awHave_next = 1'b1;
      awAddr_next = awaddr;
    end
    if (wvalid && wready)
    begin
      wHave_next  = 1'b1;
      wData_next  = wdata;
      wLane0_next = wstrb[0];
    end
    if (bvalid && bready)
      bvalid_next = 1'b0;
    if (doWrite)
    begin
      awHave_next = 1'b0;
      wHave_next  = 1'b0;
      bvalid_next = 1'b1;
      // Status and interrupt registers are read-only; writes there are ignored
      if (isReg(awAddr_reg, acr_pkg::CTRL_OFS) || isReg(awAddr_reg, acr_pkg::STAT_OFS)
          || isReg(awAddr_reg, acr_pkg::INTR_OFS))
        bresp_next = acr_pkg::RESP_OKAY;
      else
        bresp_next = acr_pkg::RESP_SLVERR;
    end
    if (rvalid && rready)
      rvalid_next = 1'b0;
    if (arvalid && arready)
    begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = acr_pkg::RESP_OKAY;
      // Request bits self-clear, so control reads as zero
      if (isReg(araddr, acr_pkg::CTRL_OFS))
        rdata_next = '0;
      else if (isReg(araddr, acr_pkg::STAT_OFS))
      begin
        rdata_next[acr_pkg::STAT_DIAG_BIT]    = diagActiveReg;
        rdata_next[acr_pkg::STAT_INITREQ_BIT] = initReqReg;
        rdata_next[acr_pkg::STAT_SCSIRST_BIT] = !scsiRstInN;
      end
      else if (isReg(araddr, acr_pkg::INTR_OFS))
      begin
        rdata_next[acr_pkg::INTR_SEEN_BIT]  = seenReg;
        rdata_next[acr_pkg::INTR_VALID_BIT] = intvReg;
      end
      else
        rresp_next = acr_pkg::RESP_SLVERR;
    end
    awready_next = !awHave_next;
    wready_next  = !wHave_next;
    arready_next = !rvalid_next;
  end

  // Bus slave registers; the slave survives a software hard reset so its answer is not lost
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      awHave_reg <= 1'b0;
      wHave_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wLane0_reg <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= acr_pkg::RESP_OKAY;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= acr_pkg::RESP_OKAY;
    end
    else
    begin
      awHave_reg <= awHave_next;
      wHave_reg  <= wHave_next;
      awAddr_reg <= awAddr_next;
      wData_reg  <= wData_next;
      wLane0_reg <= wLane0_next;
      awready    <= awready_next;
      wready     <= wready_next;
      bvalid     <= bvalid_next;
      bresp      <= bresp_next;
      arready    <= arready_next;
      rvalid     <= rvalid_next;
      rdata      <= rdata_next;
      rresp      <= rresp_next;
    end
  end

  // ==========================================================================
  // Reset sequencer next state; later assignments win, so a set beats a written clear, and host reset beats both
  always_comb
  begin
    state_next   = stateReg;
    cause_next   = causeReg;
    timer_next   = timerReg;
    seen_next    = seenReg;
    interrupt_valid_flag_next    = intvReg;
    initReq_next = initReqReg;
    win_next     = winActive ? winReg - 1'b1 : winReg;
    evt_next     = '0;
    if (intClrHit)
    begin
      seen_next = 1'b0;
      interrupt_valid_flag_next = 1'b0;
    end
    if (initDoneHit)
      initReq_next = 1'b0;
    case (stateReg)
      acr_pkg::ST_DRIVE:
        if (timerReg != '0)
          timer_next = timerReg - 1'b1;
        else if (causeReg == acr_pkg::CAUSE_HOST)
        begin
          state_next = acr_pkg::ST_DIAG;
          timer_next = DIAG_LOAD;
        end
        else
        begin
          state_next        = acr_pkg::ST_BUSFREE;
          evt_next.softReset = 1'b1;
          if (causeReg == acr_pkg::CAUSE_PHASE)
          begin
            seen_next = 1'b1;
            interrupt_valid_flag_next = 1'b1;
            win_next  = WIN_LOAD;
          end
        end
      acr_pkg::ST_DIAG:
        if (timerReg != '0)
          timer_next = timerReg - 1'b1;
        else
        begin
          state_next   = acr_pkg::ST_IDLE;
          initReq_next = 1'b1;
        end
      acr_pkg::ST_IDLE:
        if (busReqHit && !winActive)
        begin
          state_next = acr_pkg::ST_DRIVE;
          cause_next = acr_pkg::CAUSE_REQ;
          timer_next = HOLD_LOAD;
        end
        else if (sensedHit)
        begin
          state_next         = acr_pkg::ST_BUSFREE;
          seen_next          = 1'b1;
          interrupt_valid_flag_next          = 1'b1;
          win_next           = WIN_LOAD;
          evt_next.softReset = 1'b1;
        end
        else if (phaseError && !busReqHit)
        begin
          state_next = acr_pkg::ST_DRIVE;
          cause_next = acr_pkg::CAUSE_PHASE;
          timer_next = HOLD_LOAD;
        end
      default:
        if (scsiRstInN)
          state_next = acr_pkg::ST_IDLE; // Bus free once reset is released
    endcase
    // Soft to hard conversion without a second bus reset
    if (convHit)
    begin
      evt_next.ccbAbandon   = 1'b1;
      evt_next.abortPending = 1'b1;
      initReq_next          = 1'b1;
      win_next              = '0;
    end
    // Host reset outranks everything and restarts from the power-on point
    if (hostRst)
    begin
      state_next            = acr_pkg::ST_DRIVE;
      cause_next            = acr_pkg::CAUSE_HOST;
      timer_next            = HOLD_LOAD;
      seen_next             = 1'b0;
      interrupt_valid_flag_next             = 1'b0;
      initReq_next          = 1'b0;
      win_next              = '0;
      evt_next.abortPending = 1'b1;
    end
    evt_next.moduleInit    = state_next == acr_pkg::ST_DRIVE && cause_next == acr_pkg::CAUSE_HOST;
    evt_next.phaseOverride = state_next == acr_pkg::ST_DRIVE || state_next == acr_pkg::ST_BUSFREE;
    diagActive_next        = state_next == acr_pkg::ST_DIAG;
    scsiRstOe_next         = state_next == acr_pkg::ST_DRIVE;
    hostIrq_next           = interrupt_valid_flag_next;
  end

  // Sequencer registers; power-on starts in the host reset drive phase
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stateReg      <= acr_pkg::ST_DRIVE;
      causeReg      <= acr_pkg::CAUSE_HOST;
      timerReg      <= HOLD_LOAD;
      winReg        <= '0;
      seenReg       <= 1'b0;
      intvReg       <= 1'b0;
      initReqReg    <= 1'b0;
      diagActiveReg <= 1'b0;
      scsiRstOe     <= 1'b1;
      scsiRstOutN   <= 1'b0;
      hostIrq       <= 1'b0;
      evtOut        <= 5'h19;
    end
    else
    begin
      stateReg      <= state_next;
      causeReg      <= cause_next;
      timerReg      <= timer_next;
      winReg        <= win_next;
      seenReg       <= seen_next;
      intvReg       <= interrupt_valid_flag_next;
      initReqReg    <= initReq_next;
      diagActiveReg <= diagActive_next;
      scsiRstOe     <= scsiRstOe_next;
      scsiRstOutN   <= 1'b0; // Open drain: only the enable toggles
      hostIrq       <= hostIrq_next;
      evtOut        <= evt_next;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_hostDriveDone;
    stateReg == acr_pkg::ST_DRIVE && causeReg == acr_pkg::CAUSE_HOST && timerReg == '0 && !hostRst;
  endsequence
  sequence s_diagRuns;
    diagActiveReg [*8];
  endsequence

  property p_hostBus;
    hostBusReset |=> evtOut.moduleInit && !initReqReg;
  endproperty
  a_hostBus: assert property (p_hostBus) else $error("host bus reset not taken");
  property p_hardReq;
    hardReqHit |=> stateReg == acr_pkg::ST_DRIVE && causeReg == acr_pkg::CAUSE_HOST && scsiRstOe;
  endproperty
  a_hardReq: assert property (p_hardReq) else $error("hard request did not reset");
  property p_hostDrive;
    hostRst |=> scsiRstOe [*2];
  endproperty
  a_hostDrive: assert property (p_hostDrive) else $error("no bus reset on host reset");
  property p_abort;
    hostRst |=> evtOut.abortPending && evtOut.moduleInit;
  endproperty
  a_abort: assert property (p_abort) else $error("pending work not aborted");
  property p_diag;
    s_hostDriveDone |=> s_diagRuns;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic flag not held");
  property p_initAfterDiag;
    $fell(diagActiveReg) && !$past(hostRst) |-> initReqReg;
  endproperty
  a_initAfterDiag: assert property (p_initAfterDiag) else $error("init flag missing after diag");
  property p_reqNoSeen;
    stateReg == acr_pkg::ST_DRIVE && causeReg == acr_pkg::CAUSE_REQ |=> !$rose(seenReg);
  endproperty
  a_reqNoSeen: assert property (p_reqNoSeen) else $error("seen flag set on host request");
  property p_phase;
    stateReg == acr_pkg::ST_IDLE && phaseError && scsiRstInN && !busReqHit && !hostRst
      |=> scsiRstOe && causeReg == acr_pkg::CAUSE_PHASE;
  endproperty
  a_phase: assert property (p_phase) else $error("phase error not reset");
  property p_phaseFlag;
    stateReg == acr_pkg::ST_DRIVE && causeReg == acr_pkg::CAUSE_PHASE && timerReg == '0 && !hostRst
      |=> seenReg && intvReg && hostIrq;
  endproperty
  a_phaseFlag: assert property (p_phaseFlag) else $error("phase reset not flagged");
  property p_sensed;
    sensedHit && !hostRst |=> seenReg && hostIrq && evtOut.softReset && evtOut.phaseOverride;
  endproperty
  a_sensed: assert property (p_sensed) else $error("sensed reset not flagged");
  property p_valid;
    seenReg |-> intvReg && hostIrq;
  endproperty
  a_valid: assert property (p_valid) else $error("seen flag without valid");
  property p_conv;
    convHit && !hostRst |=> evtOut.ccbAbandon && !scsiRstOe && initReqReg;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion drove bus");
  property p_clear;
    hostRst |=> !seenReg && !intvReg && !hostIrq;
  endproperty
  a_clear: assert property (p_clear) else $error("interrupt not cleared");

endmodule : acr_adapter_reset_control

// [acr_pkg.sv]
// Operation
// - Host bus reset line fully resets the adapter to its power-on state.
// - Writing the hard reset request bit resets only this adapter, immediately.
// - Every host-initiated reset drives the SCSI bus reset condition.
// - Host-initiated reset puts all internal module control registers in known state.
// - Host-initiated reset aborts pending work and clears all pending structures.
// - After host reset diagnostics run while the diagnostic active flag stays set.
// - Hard reset completion sets the init required flag in status.
// - SCSI reset overrides any bus phase; bus free follows each reset.
// - Bus reset request drives SCSI reset without setting the reset seen flag.
// - Invalid bus phase detected causes a normal driven SCSI bus reset.
// - After phase-error reset, raise interrupt and set reset seen and valid flags.
// - Reset driven by another device is detected, interrupted, and flagged.
// - SCSI bus reset follows soft option: keep state, resume identified commands.
// - Adapter alone does only soft reset; hard form needs host action.
// - Timely conversion abandons command blocks, awaits init, no second bus reset.
// - Hard reset request after detection gives power-on state and second bus reset.
// - Reset seen flag is interrupt bit 3, valid only with valid flag.
// - Interrupt valid flag is bit 7 and mirrors the host interrupt level.
// - Hard reset, soft reset or power-on clears the interrupt register. Here a soft reset leaves it unchanged, or sets seen and valid.
package acr_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned SCSI_RST_HOLD_NS  = 25000;
  localparam int unsigned SCSI_RST_HOLD_CYC = (SCSI_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_WINDOW_US    = 290;
  localparam int unsigned CONV_WINDOW_CYC   = (CONV_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned DIAG_CYC          = 64;
  localparam int unsigned TMR_W             = 16;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] INTR_OFS = 4'h8;
  localparam int unsigned CTRL_HARD_BIT     = 0;
  localparam int unsigned CTRL_BUSRST_BIT   = 1;
  localparam int unsigned CTRL_INTCLR_BIT   = 2;
  localparam int unsigned CTRL_INITDONE_BIT = 3;
  localparam int unsigned STAT_DIAG_BIT     = 0;
  localparam int unsigned STAT_INITREQ_BIT  = 1;
  localparam int unsigned STAT_SCSIRST_BIT  = 2;
  localparam int unsigned INTR_SEEN_BIT     = 3;
  localparam int unsigned INTR_VALID_BIT    = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ST_DRIVE, ST_DIAG, ST_IDLE, ST_BUSFREE} acr_state_e;
  typedef enum logic [1:0] {CAUSE_HOST, CAUSE_REQ, CAUSE_PHASE} acr_cause_e;
  typedef struct packed {
    logic moduleInit;    // Internal control registers held in known state
    logic abortPending;  // Pulse: drop all pending work
    logic softReset;     // Pulse: soft reset, keep status and pointers
    logic ccbAbandon;    // Pulse: abandon all command control blocks
    logic phaseOverride; // Reset owns the bus until bus free
  } acr_evt_s;

endpackage : acr_pkg

// [acr_scsi_bus_model.sv]
`timescale 1ns/1ps
module acr_scsi_bus_model (
  input  wire logic mclk,        // Bench clock
  input  wire logic otherRst,    // Start a reset by another device
  input  wire logic scsiRstOutN, // Adapter drive level
  input  wire logic scsiRstOe,   // Adapter drive enable
  output logic      scsiRstInN   // Wire level seen by adapter
);
  int unsigned holdCnt = 0;

  // ==========================================================================
  // Another initiator
  // Holds the wire a fixed span, long enough to outlast a register access
  always @(posedge mclk)
  begin
    if (otherRst)
      holdCnt <= 25;
    else if (holdCnt != 0)
      holdCnt <= holdCnt - 1;
  end

  // Terminated open-drain wire: low while anyone pulls, pulled high otherwise
  assign scsiRstInN = !((scsiRstOe && !scsiRstOutN) || holdCnt != 0);
endmodule : acr_scsi_bus_model

// [test_adapter_reset_control.sv]
`timescale 1ns/1ps
module test_adapter_reset_control;
  logic              mclk, scsiRstInN, scsiRstOutN, scsiRstOe, hostIrq, awready, wready, bvalid;
  logic              arready, rvalid;
  logic              sys_rst = 1'b1, hostBusReset = 1'b0, phaseError = 1'b0, otherRst = 1'b0, sawDrive = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]        awaddr = 4'h0, araddr = 4'h0;
  logic [31:0]       wdata = 32'h0, rdata, rd;
  logic [1:0]        bresp, rresp, rs;
  acr_pkg::acr_evt_s evtOut, sawEvt = '0;
  int                n_fail = 0, compares = 0, cnt;

  acr_adapter_reset_control #(.CONV_CYC(200)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .hostBusReset(hostBusReset), .phaseError(phaseError),
    .scsiRstInN(scsiRstInN), .scsiRstOutN(scsiRstOutN), .scsiRstOe(scsiRstOe), .hostIrq(hostIrq),
    .evtOut(evtOut), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready));
  acr_scsi_bus_model i_bus (.mclk(mclk), .otherRst(otherRst), .scsiRstOutN(scsiRstOutN),
    .scsiRstOe(scsiRstOe), .scsiRstInN(scsiRstInN));

  // ==========================================================================
  // Clock, monitors, watchdog
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Sticky flags on the falling edge, so pulses between checks are not lost
  always @(negedge mclk)
  begin
    sawEvt <= sawEvt | evtOut;
    sawDrive <= sawDrive | scsiRstOe;
  end
  initial
  begin
    #(20 * 40000);
    n_fail++;
    conclude;
  end

  // ==========================================================================
  // Shared tasks
  task automatic conclude;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Ready may arrive per channel in any order; only the watchdog ends a wait
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, acr_pkg::RESP_OKAY);
    @(posedge mclk);
  endtask : axiWr
  task automatic axiRd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axiRd
  task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
    axiRd(a);
    chk(rd, exp);
    chk(rs, acr_pkg::RESP_OKAY);
  endtask : rdChk
  task automatic waitOe(input logic lvl, input int lim);
    cnt = 0;
    while (scsiRstOe !== lvl && cnt < lim)
    begin
      @(posedge mclk);
      cnt++;
    end
    chk(scsiRstOe, lvl);
  endtask : waitOe
  // ==========================================================================
  // Scenarios
  task automatic tReset;
    waitOe(1'b0, 1400);
    chk(32'(cnt > 1200), 32'h1);
    rdChk(acr_pkg::STAT_OFS, 32'h1);
    repeat (70) @(posedge mclk);
    rdChk(acr_pkg::STAT_OFS, 32'h2);
    rdChk(acr_pkg::INTR_OFS, 32'h0);
  endtask : tReset
  task automatic tBusReq;
    axiWr(acr_pkg::CTRL_OFS, 32'h8);
    rdChk(acr_pkg::STAT_OFS, 32'h0);
    axiWr(acr_pkg::CTRL_OFS, 32'h2);
    waitOe(1'b1, 5);
    waitOe(1'b0, 1300);
    rdChk(acr_pkg::INTR_OFS, 32'h0);
  endtask : tBusReq
  task automatic tPhase;
    sawEvt = '0;
    // One-cycle phase error strobe
    phaseError <= 1'b1;
    @(posedge mclk);
    phaseError <= 1'b0;
    waitOe(1'b1, 4);
    waitOe(1'b0, 1300);
    repeat (2) @(posedge mclk);
    rdChk(acr_pkg::INTR_OFS, 32'h88);
    chk(hostIrq, 1'b1);
    chk(sawEvt.softReset, 1'b1);
    axiWr(acr_pkg::CTRL_OFS, 32'h4);
    rdChk(acr_pkg::INTR_OFS, 32'h0);
    chk(hostIrq, 1'b0);
  endtask : tPhase
  // A reset by another device, then conversion (hard=0) or a full hard reset
  task automatic tOther(input logic hard);
    sawEvt = '0;
    sawDrive = 1'b0;
    otherRst <= 1'b1;
    @(posedge mclk);
    otherRst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(hostIrq, 1'b1);
    chk(sawEvt.phaseOverride, 1'b1);
    chk(sawEvt.softReset, 1'b1);
    rdChk(acr_pkg::INTR_OFS, 32'h88);
    chk(sawDrive, 1'b0);
    axiWr(acr_pkg::CTRL_OFS, hard ? 32'h1 : 32'h2);
    if (hard)
    begin
      waitOe(1'b1, 5);
      rdChk(acr_pkg::INTR_OFS, 32'h0);
      waitOe(1'b0, 1400);
      repeat (70) @(posedge mclk);
    end
    else
    begin
      repeat (30) @(posedge mclk);
      chk(sawDrive, 1'b0);
      chk(sawEvt.ccbAbandon, 1'b1);
    end
    rdChk(acr_pkg::STAT_OFS, 32'h2);
  endtask : tOther
  task automatic tHostReset;
    sawEvt = '0;
    hostBusReset <= 1'b1;
    @(posedge mclk);
    hostBusReset <= 1'b0;
    waitOe(1'b1, 4);
    chk(scsiRstOutN, 1'b0);
    chk(sawEvt.abortPending, 1'b1);
    chk(sawEvt.moduleInit, 1'b1);
    rdChk(acr_pkg::INTR_OFS, 32'h0);
    waitOe(1'b0, 1400);
    repeat (70) @(posedge mclk);
    rdChk(acr_pkg::STAT_OFS, 32'h2);
  endtask : tHostReset

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    chk(evtOut, 5'h19);
    chk(scsiRstOe, 1'b1);
    sys_rst <= 1'b0;
    tReset;
    tBusReq;
    tPhase;
    tOther(1'b0);
    tHostReset;
    tOther(1'b1);
    axiRd(4'hC);
    chk(rs, acr_pkg::RESP_SLVERR);
    conclude;
  end
endmodule : test_adapter_reset_control
